//--- logic/tdcspi_command_port.sv
`timescale 1ns/10ps
module tdcspi_command_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial link
    input wire logic chipSelectN,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic misoDriveN,
    // Measurement core
    input wire logic refClk,
    input wire logic [tdcspi_pkg::CHAN_COUNT-1:0] chanEmpty,
    input wire logic [tdcspi_pkg::CHAN_COUNT-1:0][23:0] refPeriodIndex,
    input wire logic [tdcspi_pkg::CHAN_COUNT-1:0][19:0] stopTimeValue,
    // Control and status
    output logic measuring,
    output logic coreRestart,
    output logic porBusy,
    output logic stopsOpen,
    output logic [19:0] refPeriodSubdivisions,
    output logic [tdcspi_pkg::CFG_COUNT-1:0][7:0] configBytes
);
    tdcspi_pkg::tdcspi_core_type coreState_reg;
    tdcspi_pkg::tdcspi_core_type coreState_next;
    logic sckRise;
    logic sckFall;
    logic refRise;
    logic [7:0] byteIn;
    logic byteDone;
    logic opcodeDone;
    logic [tdcspi_pkg::ADDR_W-1:0] selAddr;
    logic selCfg;
    logic [7:0] readByte;
    logic [tdcspi_pkg::RES_COUNT-1:0][7:0] resBytes;
    logic [tdcspi_pkg::ADDR_W-1:0] resIdx;

    tdcspi_gate_if gateBus();

    tdcspi_edge_det sckEdge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .level(sck),
        .rise(sckRise),
        .fall(sckFall)
    );

    tdcspi_edge_det refEdge (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .level(refClk),
        .rise(refRise),
        .fall()
    );

    tdcspi_gate_timer gateTimer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .gate(gateBus.timer)
    );

    assign gateBus.restart = coreState_reg.restart;
    assign gateBus.halt = coreState_reg.halt;
    assign gateBus.refTick = refRise;

    assign refPeriodSubdivisions = {coreState_reg.cfg[tdcspi_pkg::SUBDIV_ADDR + 2][3:0],
        coreState_reg.cfg[tdcspi_pkg::SUBDIV_ADDR + 1],
        coreState_reg.cfg[tdcspi_pkg::SUBDIV_ADDR]};

    // Result bytes per channel: three index bytes then three stop bytes, MSB first
    always_comb begin
        logic [23:0] idxField;
        logic [19:0] stopVal;
        logic [23:0] stopField;
        idxField = '0;
        stopVal = '0;
        stopField = '0;
        resBytes = '0;
        for (int c = 0; c < tdcspi_pkg::CHAN_COUNT; c++) begin
            // Output width settings are deliberately not consulted here
            if (refPeriodIndex[c] > tdcspi_pkg::IDX_SAT_MAX) begin
                idxField = tdcspi_pkg::IDX_SAT_MAX;
            end else begin
                idxField = refPeriodIndex[c];
            end
            stopVal = stopTimeValue[c];
            if (refPeriodSubdivisions != tdcspi_pkg::SUBDIV_NONE &&
                stopVal >= refPeriodSubdivisions) begin
                stopVal = refPeriodSubdivisions - 20'h0_0001;
            end
            stopField = {4'h0, stopVal};
            if (chanEmpty[c]) begin
                idxField = tdcspi_pkg::EMPTY_MARK;
                stopField = tdcspi_pkg::EMPTY_MARK;
            end
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 0] = idxField[23:16];
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 1] = idxField[15:8];
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 2] = idxField[7:0];
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 3] = stopField[23:16];
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 4] = stopField[15:8];
            resBytes[c * tdcspi_pkg::BYTES_PER_CHAN + 5] = stopField[7:0];
        end
    end

    assign byteIn = {coreState_reg.shiftIn[6:0], mosi};
    assign byteDone = !chipSelectN && sckFall && coreState_reg.bitCnt == tdcspi_pkg::LAST_BIT;
    assign opcodeDone = byteDone && coreState_reg.phase == tdcspi_pkg::SHIFT_OPCODE &&
        coreState_reg.holdCnt == '0;

    // Byte to present next: the opcode's address, or the one after the current
    always_comb begin
        if (coreState_reg.phase == tdcspi_pkg::SHIFT_OPCODE) begin
            selAddr = byteIn[tdcspi_pkg::ADDR_W-1:0];
            selCfg = byteIn[7:5] == tdcspi_pkg::OPC_READ_CFG;
        end else begin
            selAddr = coreState_reg.addr + 5'h01;
            selCfg = coreState_reg.readCfg;
        end
        resIdx = selAddr - 5'(tdcspi_pkg::RES_FIRST);
        readByte = 8'h00;
        if (selCfg) begin
            if (selAddr < 5'(tdcspi_pkg::CFG_COUNT)) begin
                readByte = coreState_reg.cfg[selAddr];
            end
        end else if (selAddr >= 5'(tdcspi_pkg::RES_FIRST)) begin
            readByte = resBytes[resIdx];
        end
    end

    always_comb begin
        coreState_next = coreState_reg;
        coreState_next.restart = 1'h0;
        coreState_next.halt = 1'h0;
        if (coreState_reg.holdCnt != '0) begin
            coreState_next.holdCnt = coreState_reg.holdCnt - 1'h1;
        end
        if (chipSelectN) begin
            coreState_next.phase = tdcspi_pkg::SHIFT_OPCODE;
            coreState_next.bitCnt = '0;
        end else begin
            if (sckRise && coreState_reg.phase == tdcspi_pkg::READ_DATA) begin
                coreState_next.misoBit = coreState_reg.shiftOut[7];
                coreState_next.shiftOut = {coreState_reg.shiftOut[6:0], 1'h0};
            end
            if (sckFall) begin
                coreState_next.shiftIn = byteIn;
                coreState_next.bitCnt = coreState_reg.bitCnt + 3'h1;
            end
            if (byteDone) begin
                unique case (coreState_reg.phase)
                    tdcspi_pkg::SHIFT_OPCODE: begin
                        coreState_next.phase = tdcspi_pkg::DISCARD;
                        coreState_next.addr = byteIn[tdcspi_pkg::ADDR_W-1:0];
                        if (coreState_reg.holdCnt != '0) begin
                            coreState_next.addr = coreState_reg.addr;
                        end else if (byteIn == tdcspi_pkg::OPC_POWER) begin
                            coreState_next.cfg = tdcspi_pkg::CFG_DEFAULTS;
                            coreState_next.measuring = 1'h0;
                            coreState_next.halt = 1'h1;
                            coreState_next.holdCnt = tdcspi_pkg::HOLD_W'(tdcspi_pkg::HOLD_CYCLES);
                        end else if (byteIn == tdcspi_pkg::OPC_INIT) begin
                            // Queued results are kept; the core only sees a restart
                            coreState_next.measuring = 1'h1;
                            coreState_next.restart = 1'h1;
                        end else if (byteIn[7:5] == tdcspi_pkg::OPC_WRITE_CFG) begin
                            coreState_next.phase = tdcspi_pkg::WRITE_DATA;
                        end else if (byteIn[7:5] == tdcspi_pkg::OPC_READ_CFG ||
                            byteIn[7:5] == tdcspi_pkg::OPC_READ_RES) begin
                            coreState_next.phase = tdcspi_pkg::READ_DATA;
                            coreState_next.readCfg = selCfg;
                            coreState_next.shiftOut = readByte;
                        end else begin
                            coreState_next.addr = coreState_reg.addr;
                        end
                    end
                    tdcspi_pkg::WRITE_DATA: begin
                        if (coreState_reg.addr < 5'(tdcspi_pkg::CFG_COUNT)) begin
                            coreState_next.cfg[coreState_reg.addr] = byteIn;
                        end
                        coreState_next.addr = coreState_reg.addr + 5'h01;
                    end
                    tdcspi_pkg::READ_DATA: begin
                        coreState_next.addr = coreState_reg.addr + 5'h01;
                        coreState_next.shiftOut = readByte;
                    end
                    tdcspi_pkg::DISCARD: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            coreState_reg <= '0;
        end else begin
            coreState_reg <= coreState_next;
        end
    end

    assign miso = coreState_reg.misoBit;
    assign misoDriveN = chipSelectN || coreState_reg.phase != tdcspi_pkg::READ_DATA;
    assign measuring = coreState_reg.measuring;
    assign coreRestart = coreState_reg.restart;
    assign porBusy = coreState_reg.holdCnt != '0;
    assign stopsOpen = gateBus.stopsOpen;
    assign configBytes = coreState_reg.cfg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    chk_miso_release: assert property (chipSelectN |-> misoDriveN)
        else $error("data-out driven while chip-select is high");
    chk_por_defaults: assert property (opcodeDone && byteIn == tdcspi_pkg::OPC_POWER
        |=> coreState_reg.cfg == tdcspi_pkg::CFG_DEFAULTS && !measuring && porBusy)
        else $error("power opcode did not restore defaults and stop measurement");
    chk_por_hold_len: assert property ($rose(porBusy)
        |-> coreState_reg.holdCnt == tdcspi_pkg::HOLD_W'(tdcspi_pkg::HOLD_CYCLES))
        else $error("power reset hold interval has wrong length");
    chk_por_refuse: assert property (porBusy && byteDone
        |=> $stable(coreState_reg.cfg) && coreState_reg.phase == tdcspi_pkg::DISCARD)
        else $error("access accepted during power reset hold");
    chk_init_keeps_cfg: assert property (opcodeDone && byteIn == tdcspi_pkg::OPC_INIT
        |=> measuring && coreRestart && coreState_reg.cfg == $past(coreState_reg.cfg)
        ##1 !stopsOpen)
        else $error("init opcode did not restart with configuration kept");
    chk_write_store: assert property (byteDone && coreState_reg.phase == tdcspi_pkg::WRITE_DATA
        && coreState_reg.addr < 5'(tdcspi_pkg::CFG_COUNT)
        |=> coreState_reg.cfg[$past(coreState_reg.addr)] == $past(byteIn))
        else $error("write data byte not stored at addressed register");
    chk_addr_advance: assert property (byteDone && (coreState_reg.phase == tdcspi_pkg::WRITE_DATA
        || coreState_reg.phase == tdcspi_pkg::READ_DATA)
        |=> coreState_reg.addr == $past(coreState_reg.addr) + 5'h01)
        else $error("burst address did not advance by one");
    chk_read_msb_first: assert property (sckRise && !chipSelectN
        && coreState_reg.phase == tdcspi_pkg::READ_DATA
        |=> miso == $past(coreState_reg.shiftOut[7]))
        else $error("read data not shifted out MSB first on rising edge");
    chk_unknown_ignored: assert property (opcodeDone && byteIn != tdcspi_pkg::OPC_POWER
        && byteIn != tdcspi_pkg::OPC_INIT && byteIn[7:5] != tdcspi_pkg::OPC_WRITE_CFG
        && byteIn[7:5] != tdcspi_pkg::OPC_READ_CFG && byteIn[7:5] != tdcspi_pkg::OPC_READ_RES
        |=> $stable(coreState_reg.cfg) && $stable(measuring) && !coreRestart)
        else $error("unknown opcode changed device state");
    chk_cs_resets: assert property (chipSelectN
        |=> coreState_reg.phase == tdcspi_pkg::SHIFT_OPCODE && coreState_reg.bitCnt == '0)
        else $error("chip-select high did not reset the serial logic");
    chk_shift_idle: assert property (chipSelectN
        |=> $stable(coreState_reg.shiftIn))
        else $error("serial input shifted while chip-select was high");
    chk_mosi_capture: assert property (sckFall && !chipSelectN
        |=> coreState_reg.shiftIn[0] == $past(mosi))
        else $error("serial input bit not taken on the falling clock edge");
    chk_miso_drive: assert property (!chipSelectN
        && coreState_reg.phase == tdcspi_pkg::READ_DATA
        |-> !misoDriveN)
        else $error("data-out not driven during a read");
    chk_read_load: assert property (opcodeDone
        && (byteIn[7:5] == tdcspi_pkg::OPC_READ_CFG
        || byteIn[7:5] == tdcspi_pkg::OPC_READ_RES)
        |=> coreState_reg.shiftOut == $past(readByte) && !misoDriveN)
        else $error("read opcode did not load the addressed register");
    chk_result_low: assert property (opcodeDone
        && byteIn[7:5] == tdcspi_pkg::OPC_READ_RES
        && byteIn[tdcspi_pkg::ADDR_W-1:0] < 5'(tdcspi_pkg::RES_FIRST)
        |=> coreState_reg.shiftOut == 8'h00)
        else $error("read below the result registers returned data");
    chk_write_bounds: assert property (byteDone
        && coreState_reg.phase == tdcspi_pkg::WRITE_DATA
        && coreState_reg.addr >= 5'(tdcspi_pkg::CFG_COUNT)
        |=> $stable(coreState_reg.cfg))
        else $error("write beyond the configuration registers changed them");
    chk_restart_pulse: assert property (coreRestart
        |=> !coreRestart && !stopsOpen)
        else $error("restart not a single pulse or stops left open");
    chk_halt_closes: assert property (coreState_reg.halt
        |=> !stopsOpen && !measuring)
        else $error("power reset left stop channels open or measuring");
    chk_hold_count: assert property (porBusy
        |=> coreState_reg.holdCnt == $past(coreState_reg.holdCnt) - 1'h1)
        else $error("power reset hold did not count down");

    // Result field coding, checked per channel on the bytes offered for readout
    for (genvar ch = 0; ch < tdcspi_pkg::CHAN_COUNT; ch++) begin : gChanCheck
        localparam int BASE = ch * tdcspi_pkg::BYTES_PER_CHAN;
        logic [23:0] idxSeen;
        logic [23:0] stopSeen;
        assign idxSeen = {resBytes[BASE], resBytes[BASE + 1], resBytes[BASE + 2]};
        assign stopSeen = {resBytes[BASE + 3], resBytes[BASE + 4], resBytes[BASE + 5]};

        chk_empty_marker: assert property (chanEmpty[ch]
            |-> idxSeen == tdcspi_pkg::EMPTY_MARK && stopSeen == tdcspi_pkg::EMPTY_MARK)
            else $error("empty channel did not read the all-ones marker");
        chk_stop_width: assert property (!chanEmpty[ch]
            |-> stopSeen[23:20] == 4'h0)
            else $error("stop result uses more than twenty bits");
        chk_stop_range: assert property (!chanEmpty[ch]
            && refPeriodSubdivisions != tdcspi_pkg::SUBDIV_NONE
            |-> stopSeen[19:0] < refPeriodSubdivisions)
            else $error("stop result reached the subdivision count");
        chk_index_sat: assert property (!chanEmpty[ch]
            |-> idxSeen <= tdcspi_pkg::IDX_SAT_MAX)
            else $error("reference index above its saturation value");
    end

    // Main scenarios

    cov_power: cover property (opcodeDone && byteIn == tdcspi_pkg::OPC_POWER);
    cov_init_open: cover property ($rose(stopsOpen));
    cov_write_burst: cover property (byteDone && coreState_reg.phase == tdcspi_pkg::WRITE_DATA
        ##[1:200] byteDone && coreState_reg.phase == tdcspi_pkg::WRITE_DATA);
    cov_read_burst: cover property (byteDone && coreState_reg.phase == tdcspi_pkg::READ_DATA);
    cov_result_read: cover property (opcodeDone && byteIn[7:5] == tdcspi_pkg::OPC_READ_RES);
endmodule

//--- logic/tdcspi_edge_det.sv
`timescale 1ns/10ps
module tdcspi_edge_det #(
    parameter logic RESET_LEVEL = 1'h0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Sampled level and its edges
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_reg;
    logic prev_next;

    always_comb begin
        prev_next = level;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_reg <= RESET_LEVEL;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign rise = level && !prev_reg;
    assign fall = !level && prev_reg;
endmodule

//--- logic/tdcspi_gate_if.sv
`timescale 1ns/10ps
interface tdcspi_gate_if;
    logic restart;
    logic halt;
    logic refTick;
    logic stopsOpen;
    modport ctrl(output restart, output halt, output refTick, input stopsOpen);
    modport timer(input restart, input halt, input refTick, output stopsOpen);
endinterface

//--- logic/tdcspi_gate_timer.sv
`timescale 1ns/10ps
module tdcspi_gate_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control from the command port
    tdcspi_gate_if.timer gate
);
    tdcspi_pkg::tdcspi_gate_type gate_reg;
    tdcspi_pkg::tdcspi_gate_type gate_next;

    always_comb begin
        gate_next = gate_reg;
        if (gate.halt) begin
            gate_next = '0;
        end else if (gate.restart) begin
            gate_next.counting = 1'h1;
            gate_next.open = 1'h0;
            gate_next.pulses = '0;
        end else if (gate.refTick && gate_reg.counting) begin
            gate_next.pulses = gate_reg.pulses + 1'h1;
            // Stops open only after the full count of reference pulses
            if (gate_next.pulses == tdcspi_pkg::GATE_W'(tdcspi_pkg::REF_OPEN_PULSES)) begin
                gate_next.counting = 1'h0;
                gate_next.open = 1'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_reg <= '0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    assign gate.stopsOpen = gate_reg.open;

    chk_gate_open_count: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(gate_reg.open) |-> $past(gate_reg.pulses) ==
            tdcspi_pkg::GATE_W'(tdcspi_pkg::REF_OPEN_PULSES - 1) && $past(gate.refTick))
        else $error("stops opened before the reference pulse count was reached");
endmodule

//--- logic/tdcspi_pkg.sv
package tdcspi_pkg;

    // Opcodes: full bytes for the two resets, top three bits for the access type
    localparam logic [7:0] OPC_POWER = 8'h30;
    localparam logic [7:0] OPC_INIT = 8'h18;
    localparam logic [2:0] OPC_WRITE_CFG = 3'h4;
    localparam logic [2:0] OPC_READ_RES = 3'h3;
    localparam logic [2:0] OPC_READ_CFG = 3'h2;

    // Register space
    localparam int ADDR_W = 5;
    localparam int CFG_COUNT = 18;
    localparam int RES_FIRST = 8;
    localparam int CHAN_COUNT = 4;
    localparam int BYTES_PER_CHAN = 6;
    localparam int RES_COUNT = CHAN_COUNT * BYTES_PER_CHAN;
    localparam int SUBDIV_ADDR = 6;
    localparam logic [CFG_COUNT-1:0][7:0] CFG_DEFAULTS = '0;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Result coding
    localparam logic [23:0] EMPTY_MARK = 24'h0F_FFFF;
    localparam logic [23:0] IDX_SAT_MAX = 24'h00_FFFF;
    localparam logic [19:0] SUBDIV_NONE = 20'h0_0000;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SELECT_HOLD_NS = 1000;
    localparam int HOLD_CYCLES = (SELECT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam int REF_OPEN_PULSES = 16;
    localparam int GATE_W = $clog2(REF_OPEN_PULSES + 1);

    typedef enum logic [1:0] {SHIFT_OPCODE, WRITE_DATA, READ_DATA, DISCARD} tdcspi_phase_type;

    typedef struct packed {
        tdcspi_phase_type phase;
        logic [2:0] bitCnt;
        logic [7:0] shiftIn;
        logic [7:0] shiftOut;
        logic [ADDR_W-1:0] addr;
        logic readCfg;
        logic misoBit;
        logic measuring;
        logic restart;
        logic halt;
        logic [HOLD_W-1:0] holdCnt;
        logic [CFG_COUNT-1:0][7:0] cfg;
    } tdcspi_core_type;

    typedef struct packed {
        logic counting;
        logic open;
        logic [GATE_W-1:0] pulses;
    } tdcspi_gate_type;

endpackage

//--- test/tdcspi_command_port_tb_top.sv
`timescale 1ns/10ps
module tdcspi_command_port_tb_top;
    logic mclk, sys_rst, chipSelectN, sck, mosi, miso, misoDriveN, misoLine, refClk;
    logic measuring, coreRestart, porBusy, stopsOpen;
    logic [3:0] chanEmpty;
    logic [3:0][23:0] refPeriodIndex;
    logic [3:0][19:0] stopTimeValue;
    logic [19:0] refPeriodSubdivisions, subM;
    logic [17:0][7:0] configBytes;
    logic [7:0] cfgM [18];
    logic [7:0] txQ [$];
    logic [7:0] rxQ [$];
    logic measM;
    int num_errors, total_checks, cycles, restarts, porRun, r0;

    assign misoLine = misoDriveN ? 1'bz : miso;

    tdcspi_command_port DUT (.mclk(mclk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
        .sck(sck), .mosi(mosi), .miso(miso), .misoDriveN(misoDriveN), .refClk(refClk),
        .chanEmpty(chanEmpty), .refPeriodIndex(refPeriodIndex), .stopTimeValue(stopTimeValue),
        .measuring(measuring), .coreRestart(coreRestart), .porBusy(porBusy),
        .stopsOpen(stopsOpen), .refPeriodSubdivisions(refPeriodSubdivisions),
        .configBytes(configBytes));

    tdcspi_host_model host (.mclk(mclk), .chipSelectN(chipSelectN), .sck(sck), .mosi(mosi),
        .misoLine(misoLine));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (coreRestart === 1'b1) restarts++;
        if (porBusy === 1'b1) porRun++;
        if (cycles == 30000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fill(input int n);
        txQ = {};
        repeat (n) txQ.push_back(8'($urandom));
    endtask

    task automatic xfer(input logic [7:0] op);
        logic [7:0] rx;
        rxQ = {};
        host.open_xfer();
        host.shift_byte(op, rx);
        foreach (txQ[i]) begin
            host.shift_byte(txQ[i], rx);
            rxQ.push_back(rx);
        end
        host.close_xfer();
        repeat (3) @(posedge mclk);
        chk("miso released", misoDriveN, 1'b1);
    endtask

    task automatic write_cfg(input int a);
        xfer(8'h80 | 8'(a));
        foreach (txQ[i]) begin
            if ((a + i) % 32 < 18) cfgM[(a + i) % 32] = txQ[i];
        end
        subM = {cfgM[8][3:0], cfgM[7], cfgM[6]};
    endtask

    task automatic cfg_check();
        for (int i = 0; i < 18; i++) chk("config byte", configBytes[i], cfgM[i]);
        chk("subdivisions", refPeriodSubdivisions, subM);
        chk("measuring", measuring, measM);
    endtask

    function automatic logic [7:0] res_byte(input int a);
        int c;
        int k;
        logic [23:0] v;
        if (a < 8) return 8'h00;
        c = (a - 8) / 6;
        k = (a - 8) % 6;
        if (chanEmpty[c]) v = 24'h0F_FFFF;
        else if (k < 3) v = refPeriodIndex[c] > 24'h00_FFFF ? 24'h00_FFFF : refPeriodIndex[c];
        else if (subM != 0 && stopTimeValue[c] >= subM) v = 24'(subM - 1);
        else v = 24'(stopTimeValue[c]);
        return 8'(v >> (8 * (2 - k % 3)));
    endfunction

    task automatic ref_pulses(input int n);
        repeat (n) begin
            refClk <= 1'b1;
            repeat (2) @(posedge mclk);
            refClk <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask

    initial begin
        void'($urandom(94617));
        sys_rst = 1'b1;
        refClk = 1'b0;
        chanEmpty = '0;
        refPeriodIndex = '0;
        stopTimeValue = '0;
        measM = 1'b0;
        subM = '0;
        foreach (cfgM[i]) cfgM[i] = 8'h00;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        cfg_check();
        chk("stops open", stopsOpen, 1'b0);
        $display("Test reset done");
        // Full configuration, then an overlapping burst past the last register
        fill(18);
        write_cfg(0);
        fill(4);
        write_cfg(16);
        cfg_check();
        fill(19);
        xfer(8'h40);
        foreach (rxQ[i]) chk("config read", rxQ[i], i < 18 ? cfgM[i] : 8'h00);
        $display("Test config write and read done");
        foreach (txQ[i]) txQ[i] = 8'h00;
        for (logic [7:0] op = 8'h00; op < 8'hC0; op += 8'h29) begin
            fill(1);
            xfer(op != 8'h52 ? op : 8'hE5);
        end
        cfg_check();
        $display("Test unknown opcodes done");
        r0 = restarts;
        xfer(8'h18);
        measM = 1'b1;
        cfg_check();
        chk("restart pulse", restarts - r0, 1);
        // Settling pause the host owes after init
        repeat (20) @(posedge mclk);
        ref_pulses(15);
        chk("stops still closed", stopsOpen, 1'b0);
        ref_pulses(1);
        repeat (2) @(posedge mclk);
        chk("stops open", stopsOpen, 1'b1);
        xfer(8'h18);
        chk("second restart", restarts - r0, 2);
        repeat (20) @(posedge mclk);
        cfg_check();
        $display("Test init done");
        txQ = {8'h10, 8'h27, 8'h00};
        write_cfg(6);
        for (int r = 0; r < 2; r++) begin
            @(posedge mclk);
            chanEmpty <= r == 0 ? 4'b1010 : 4'($urandom);
            for (int c = 0; c < 4; c++) begin
                refPeriodIndex[c] <= 24'($urandom_range(0, 24'h01_FFFF));
                stopTimeValue[c] <= 20'($urandom_range(0, 20000));
            end
            fill(26);
            xfer(8'h66);
            foreach (rxQ[i]) chk("result byte", rxQ[i], res_byte(i + 6));
        end
        $display("Test result read done");
        // Open the stops first so that the power opcode has something to halt
        ref_pulses(16);
        repeat (2) @(posedge mclk);
        chk("stops open before power", stopsOpen, 1'b1);
        porRun = 0;
        xfer(8'h30);
        foreach (cfgM[i]) cfgM[i] = 8'h00;
        measM = 1'b0;
        subM = '0;
        repeat (12) @(posedge mclk);
        chk("power hold cycles", 24'(porRun), tdcspi_pkg::HOLD_CYCLES);
        chk("stops closed", stopsOpen, 1'b0);
        cfg_check();
        fill(2);
        write_cfg(3);
        cfg_check();
        $display("Test power reset done");
        test_done();
    end
endmodule

//--- test/tdcspi_host_model.sv
`timescale 1ns/10ps
module tdcspi_host_model (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic chipSelectN,
    output logic sck,
    output logic mosi,
    input wire logic misoLine
);
    initial begin
        chipSelectN = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // Data line toggles while deselected so a stale level never looks like data
    always @(posedge mclk) begin
        if (chipSelectN) begin
            mosi <= ~mosi;
        end
    end
    // Every access opens with a positive select pulse
    task automatic open_xfer();
        @(posedge mclk);
        chipSelectN <= 1'b1;
        repeat (3) @(posedge mclk);
        chipSelectN <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // Clock idles low, data set with the rise, taken at the fall, MSB first
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b1;
            mosi <= tx[i];
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            rx[i] = misoLine;
            @(posedge mclk);
            sck <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
    task automatic close_xfer();
        chipSelectN <= 1'b1;
        @(posedge mclk);
    endtask
endmodule
